// >>> include/wpc_pkg.sv
// Purpose: Shared constants for the white-point calibration command handler
// Assumes: Byte-serial parameter stream, least significant byte first
// Notes:   Opcodes, field sizes and reply lengths live here only
package wpc_pkg;
    // Command opcodes
    localparam logic [7:0] OP_COLOR_POINT = 8'hc4;
    localparam logic [7:0] OP_DUTY_CYCLE  = 8'hc5;
    localparam logic [7:0] OP_CAL_DATA    = 8'hc6;
    localparam logic [7:0] OP_SENSOR_OUT  = 8'hcd;
    localparam logic [7:0] OP_CAL_MODE    = 8'hd1;
    // Colour selectors
    localparam logic [7:0] COLOR_RED      = 8'h00;
    localparam logic [7:0] COLOR_GREEN    = 8'h01;
    localparam logic [7:0] COLOR_BLUE     = 8'h02;
    localparam logic [7:0] COLOR_MAX      = 8'h02;
    localparam int         NUM_COLORS     = 3;
    // Mode byte that enables bypass
    localparam logic [7:0] MODE_ENABLE    = 8'h01;
    // Parameter byte counts
    localparam logic [4:0] LEN_SET_CAL    = 5'h09;
    localparam logic [4:0] LEN_SET_MODE   = 5'h01;
    localparam logic [4:0] LEN_GET_CAL    = 5'h01;
    // Reply byte counts
    localparam logic [4:0] RLEN_POINT     = 5'h08;
    localparam logic [4:0] RLEN_DUTY      = 5'h0c;
    localparam logic [4:0] RLEN_CAL       = 5'h16;
    localparam logic [4:0] RLEN_SENSOR    = 5'h0c;
    localparam logic [4:0] RLEN_MODE      = 5'h01;
    // Reset duty cycle, 1.0 in u8.8
    localparam logic [15:0] DUTY_RESET    = 16'h0100;
endpackage

// >>> design/wpc_duty_search.sv
// Purpose: Pick the available LED duty cycle closest to the ideal one
// Assumes: Table of available duty cycles given as a packed vector
// Notes:   One entry per clock, so a search takes DEPTH cycles
`timescale 1ns/1ns
module wpc_duty_search #(
    parameter int DEPTH = 8
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              start,
    input  wire logic [15:0]       ideal,
    input  wire logic [DEPTH*16-1:0] table_in,
    output logic                   busy,
    output logic                   done,
    output logic [15:0]            best
);
    localparam int IW = $clog2(DEPTH) + 1;
    logic [IW-1:0] idx_reg;   // Current table entry
    logic [15:0]   bestErr;   // Smallest distance seen

    // Absolute distance between a candidate entry and the ideal duty
    function automatic logic [15:0] absDiff(input logic [15:0] a,
                                            input logic [15:0] b);
        absDiff = (a > b) ? a - b : b - a;
    endfunction

    logic [15:0] cand;
    assign cand = table_in[idx_reg[IW-2:0]*16 +: 16];

    // Sequential scan; first equal-best entry wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
            best    <= 16'h0000;
            bestErr <= 16'hffff;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy    <= 1'b1;
                idx_reg <= '0;
                bestErr <= 16'hffff;
            end else if (busy) begin
                if (absDiff(cand, ideal) < bestErr) begin
                    bestErr <= absDiff(cand, ideal);
                    best    <= cand;
                end
                if (idx_reg == IW'(DEPTH - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    idx_reg <= idx_reg + 1'b1;
                end
            end
        end
    end
endmodule

// >>> design/wpc_cmd_handler.sv
// Purpose: Command handler for white_point_correction calibration
// Assumes: Framing layer delivers opcode, then parameter bytes, then end
// Notes:   Replies stream out one byte per accepted ready handshake
//
// Overview of operation
// - Colour point reply: x, y, 4-byte luminance
// - Set-duty command searches and applies best duty
// - Duty reply: three ideal, three chosen u8.8
// - Set-calibration stores x, y, luminance per colour
// - Calibration reply: point, sensors, duty cycle
// - Sensor reply: red, green, blue, four bytes
// - Mode byte one enters bypass, commands still processed
// - Bypass only leaves on system restart
// - Mode get reports bypass in same format
`timescale 1ns/1ns
module wpc_cmd_handler #(
    parameter int DUTY_DEPTH = 8
) (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic                    cmdStart,
    input  wire logic [7:0]              cmdOpcode,
    input  wire logic                    cmdIsGet,
    input  wire logic                    paramValid,
    input  wire logic [7:0]              paramByte,
    input  wire logic                    cmdEnd,
    input  wire logic [15:0]             pointX,
    input  wire logic [15:0]             pointY,
    input  wire logic [31:0]             pointLum,
    input  wire logic [47:0]             sensorRgb,
    input  wire logic [47:0]             idealDuty,
    input  wire logic [DUTY_DEPTH*16-1:0] dutyTable,
    input  wire logic                    replyReady,
    output logic                         replyValid,
    output logic [7:0]                   replyByte,
    output logic                         replyLast,
    output logic                         cmdError,
    output logic                         busy,
    output logic                         bypassMode,
    output logic [47:0]                  appliedDuty
);
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_PARAM  = 4'b0010,
        ST_SEARCH = 4'b0100,
        ST_REPLY  = 4'b1000
    } wpc_state_e;

    wpc_state_e  state_reg;           // Control state
    logic [7:0]  op_reg;              // Latched opcode
    logic        get_reg;             // Latched direction
    logic [4:0]  cnt_reg;             // Parameter byte count
    logic [71:0] par_reg;             // Parameter bytes, LSB first
    logic [4:0]  rIdx_reg;            // Reply byte index
    logic [4:0]  rLen_reg;            // Reply length
    logic [175:0] reply_reg;          // Reply image, byte 0 lowest
    logic [1:0]  srchCol_reg;         // Colour under search
    // Per-colour calibration records
    logic [15:0] calX   [wpc_pkg::NUM_COLORS];
    logic [15:0] calY   [wpc_pkg::NUM_COLORS];
    logic [31:0] calLum [wpc_pkg::NUM_COLORS];
    logic [15:0] calDuty[wpc_pkg::NUM_COLORS];

    logic        srchStart, srchBusy, srchDone;
    logic [15:0] srchBest;
    logic        selOk;               // Selector in range
    logic [1:0]  sel;                 // Latched selector

    assign sel   = par_reg[1:0];
    assign selOk = (par_reg[7:0] <= wpc_pkg::COLOR_MAX);
    assign busy  = (state_reg != ST_IDLE);
    assign srchStart = (state_reg == ST_SEARCH) && !srchBusy && !srchDone;

    // Search one colour at a time against its ideal duty
    wpc_duty_search #(
        .DEPTH(DUTY_DEPTH)
    ) u_search (
        .clock   (clock),
        .rst_n   (rst_n),
        .start   (srchStart),
        .ideal   (idealDuty[srchCol_reg*16 +: 16]),
        .table_in(dutyTable),
        .busy    (srchBusy),
        .done    (srchDone),
        .best    (srchBest)
    );

    // Command sequencing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_IDLE;
            op_reg      <= 8'h00;
            get_reg     <= 1'b0;
            cnt_reg     <= 5'h00;
            par_reg     <= '0;
            rIdx_reg    <= 5'h00;
            srchCol_reg <= 2'h0;
            cmdError    <= 1'b0;
        end else begin
            cmdError <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (cmdStart) begin
                        op_reg    <= cmdOpcode;
                        get_reg   <= cmdIsGet;
                        cnt_reg   <= 5'h00;
                        par_reg   <= '0;
                        state_reg <= ST_PARAM;
                    end
                end
                ST_PARAM: begin
                    // Bytes land LSB first
                    if (paramValid && cnt_reg < wpc_pkg::LEN_SET_CAL) begin
                        par_reg[cnt_reg*8 +: 8] <= paramByte;
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                    if (cmdEnd) begin
                        rIdx_reg  <= 5'h00;
                        state_reg <= ST_IDLE;
                        if (get_reg) begin
                            if (op_reg == wpc_pkg::OP_CAL_DATA && !selOk)
                                cmdError <= 1'b1;
                            else
                                state_reg <= ST_REPLY;
                        end else if (op_reg == wpc_pkg::OP_DUTY_CYCLE) begin
                            srchCol_reg <= 2'h0;
                            state_reg   <= ST_SEARCH;
                        end else if (op_reg == wpc_pkg::OP_CAL_DATA &&
                                     (!selOk ||
                                      cnt_reg != wpc_pkg::LEN_SET_CAL)) begin
                            cmdError <= 1'b1;
                        end
                    end
                end
                ST_SEARCH: begin
                    if (srchDone) begin
                        if (srchCol_reg == 2'h2)
                            state_reg <= ST_IDLE;
                        else
                            srchCol_reg <= srchCol_reg + 1'b1;
                    end
                end
                ST_REPLY: begin
                    if (replyReady) begin
                        rIdx_reg <= rIdx_reg + 1'b1;
                        if (replyLast)
                            state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Calibration store, written only for a legal selector
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < wpc_pkg::NUM_COLORS; i++) begin
                calX[i]    <= 16'h0000;
                calY[i]    <= 16'h0000;
                calLum[i]  <= 32'h0000_0000;
            end
        end else if (state_reg == ST_PARAM && cmdEnd && !get_reg &&
                     op_reg == wpc_pkg::OP_CAL_DATA && selOk &&
                     cnt_reg == wpc_pkg::LEN_SET_CAL) begin
            calX[sel]   <= par_reg[23:8];
            calY[sel]   <= par_reg[39:24];
            calLum[sel] <= par_reg[71:40];
        end
    end

    // Applied duty cycles from the search
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < wpc_pkg::NUM_COLORS; i++)
                calDuty[i] <= wpc_pkg::DUTY_RESET;
        end else if (state_reg == ST_SEARCH && srchDone) begin
            calDuty[srchCol_reg] <= srchBest;
        end
    end
    assign appliedDuty = {calDuty[2], calDuty[1], calDuty[0]};

    // Bypass is sticky; only reset clears it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bypassMode <= 1'b0;
        end else if (state_reg == ST_PARAM && cmdEnd && !get_reg &&
                     op_reg == wpc_pkg::OP_CAL_MODE && cnt_reg != 5'h00 &&
                     par_reg[7:0] == wpc_pkg::MODE_ENABLE) begin
            bypassMode <= 1'b1;
        end
    end

    // Reply image, built when the get command closes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reply_reg <= '0;
            rLen_reg  <= 5'h00;
        end else if (state_reg == ST_PARAM && cmdEnd && get_reg) begin
            reply_reg <= '0;
            rLen_reg  <= 5'h00;
            unique case (op_reg)
                wpc_pkg::OP_COLOR_POINT: begin
                    reply_reg[63:0] <= {pointLum, pointY, pointX};
                    rLen_reg <= wpc_pkg::RLEN_POINT;
                end
                wpc_pkg::OP_DUTY_CYCLE: begin
                    reply_reg[95:0] <= {appliedDuty, idealDuty};
                    rLen_reg <= wpc_pkg::RLEN_DUTY;
                end
                wpc_pkg::OP_CAL_DATA: begin
                    reply_reg <= {calDuty[sel],
                                  16'h0000, sensorRgb[47:32],
                                  16'h0000, sensorRgb[31:16],
                                  16'h0000, sensorRgb[15:0],
                                  calLum[sel], calY[sel], calX[sel]};
                    rLen_reg <= wpc_pkg::RLEN_CAL;
                end
                wpc_pkg::OP_SENSOR_OUT: begin
                    reply_reg[95:0] <= {16'h0000, sensorRgb[47:32],
                                        16'h0000, sensorRgb[31:16],
                                        16'h0000, sensorRgb[15:0]};
                    rLen_reg <= wpc_pkg::RLEN_SENSOR;
                end
                wpc_pkg::OP_CAL_MODE: begin
                    reply_reg[7:0] <= {7'h00, bypassMode};
                    rLen_reg <= wpc_pkg::RLEN_MODE;
                end
                default: rLen_reg <= 5'h00;
            endcase
        end
    end

    // Unknown opcode yields an empty reply
    always_comb begin
        replyValid = (state_reg == ST_REPLY) && (rLen_reg != 5'h00);
        replyLast  = (state_reg == ST_REPLY) &&
                     (rLen_reg == 5'h00 || rIdx_reg == rLen_reg - 1'b1);
        replyByte  = reply_reg[rIdx_reg*8 +: 8];
    end

    property p_bypass_sticky;
        @(posedge clock) disable iff (!rst_n)
        bypassMode |=> bypassMode;
    endproperty
    a_bypass_sticky: assert property (p_bypass_sticky)
        else $error("bypass mode left without reset");

    property p_bypass_enter;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_PARAM && cmdEnd && !get_reg &&
         op_reg == wpc_pkg::OP_CAL_MODE && cnt_reg != 5'h00 &&
         par_reg[7:0] == wpc_pkg::MODE_ENABLE) |=> bypassMode;
    endproperty
    a_bypass_enter: assert property (p_bypass_enter)
        else $error("enable byte did not enter bypass");

    property p_bad_sel;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_PARAM && cmdEnd &&
         op_reg == wpc_pkg::OP_CAL_DATA && !selOk)
        |=> cmdError && $stable(calX[0]) && $stable(calLum[2]);
    endproperty
    a_bad_sel: assert property (p_bad_sel)
        else $error("bad selector not refused");

    property p_point_len;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_PARAM && cmdEnd && get_reg &&
         op_reg == wpc_pkg::OP_COLOR_POINT)
        |=> replyValid && rLen_reg == wpc_pkg::RLEN_POINT;
    endproperty
    a_point_len: assert property (p_point_len)
        else $error("colour point reply length wrong");

    // Legal calibration get always streams the full record
    property p_cal_len;
        @(posedge clock) disable iff (!rst_n)
        (state_reg == ST_PARAM && cmdEnd && get_reg &&
         op_reg == wpc_pkg::OP_CAL_DATA && selOk)
        |=> replyValid && rLen_reg == wpc_pkg::RLEN_CAL;
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("calibration reply length wrong");

    property p_search_ends;
        @(posedge clock) disable iff (!rst_n)
        $rose(state_reg == ST_SEARCH) |-> ##[1:40] state_reg == ST_IDLE;
    endproperty
    a_search_ends: assert property (p_search_ends)
        else $error("duty search did not finish");
endmodule

// >>> sim/wpc_host_model.sv
// Purpose: Host side model that issues commands and collects replies
// Assumes: Inputs change on the falling edge, replies taken on rising
// Notes:   Slow mode drops replyReady every other cycle
`timescale 1ns/1ns
module wpc_host_model (
    input  wire logic       clock,
    input  wire logic       busy,
    input  wire logic       replyValid,
    input  wire logic [7:0] replyByte,
    input  wire logic       replyLast,
    output logic            cmdStart,
    output logic [7:0]      cmdOpcode,
    output logic            cmdIsGet,
    output logic            paramValid,
    output logic [7:0]      paramByte,
    output logic            cmdEnd,
    output logic            replyReady
);
    logic [7:0] rx [0:31];  // Captured reply bytes
    int         rxn;        // Reply byte count
    int         idleErr;    // Waits on busy that ran out

    // Idle lines at time zero
    initial begin
        {cmdStart, cmdIsGet, paramValid, cmdEnd, replyReady} = '0;
        cmdOpcode = 8'h00;
        paramByte = 8'h00;
        idleErr = 0;
    end

    // Bounded wait, a new command only when the handler is idle
    task automatic wait_idle();
        int t;
        for (t = 0; t < 400 && busy !== 1'b0; t++) @(negedge clock);
        if (t == 400) idleErr++;
    endtask

    // Opcode, then n parameter bytes low byte first, then end
    task automatic send(input logic [7:0] op, input logic get,
                        input int n, input logic [71:0] pb);
        wait_idle();
        cmdStart = 1'b1;
        cmdOpcode = op;
        cmdIsGet = get;
        @(negedge clock);
        cmdStart = 1'b0;
        for (int i = 0; i < n; i++) begin
            paramValid = 1'b1;
            paramByte = pb[8*i+:8];
            @(negedge clock);
        end
        // Released data line must not look like a held byte
        paramValid = 1'b0;
        paramByte = ~paramByte;
        cmdEnd = 1'b1;
        @(negedge clock);
        cmdEnd = 1'b0;
    endtask

    // Take bytes on ready edges until the last one, bounded
    task automatic fetch(input bit slow);
        bit fin;
        rxn = 0;
        fin = 0;
        for (int t = 0; t < 200 && !fin; t++) begin
            replyReady = !(slow && t[0]);
            @(posedge clock);
            if (replyValid === 1'b1 && replyReady) begin
                rx[rxn] = replyByte;
                rxn++;
                fin = (replyLast === 1'b1);
            end
            @(negedge clock);
        end
        replyReady = 1'b0;
    endtask
endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench for the calibration command handler
// Assumes: Default duty table depth of eight entries
// Notes:   Expected replies are built from the driven inputs
`timescale 1ns/1ns
module tb;
    logic         clock, rst_n;             // Clock and reset
    logic         cmdStart, cmdIsGet;       // Command strobes
    logic         paramValid, cmdEnd;       // Parameter strobes
    logic [7:0]   cmdOpcode, paramByte;     // Command bytes
    logic         replyReady, replyValid;   // Reply handshake
    logic [7:0]   replyByte;                // Reply data
    logic         replyLast, cmdError;      // Reply end, refusal
    logic         busy, bypassMode;         // Status
    logic [15:0]  pointX, pointY;           // Colour point
    logic [31:0]  pointLum;                 // Luminance
    logic [47:0]  sensorRgb, idealDuty;     // Algorithm inputs
    logic [47:0]  appliedDuty;              // Chosen duties
    logic [127:0] dutyTable;                // Available duties
    int num_errors, check_count, errSeen, cycles;

    wpc_cmd_handler u_dut (.clock(clock), .rst_n(rst_n),
        .cmdStart(cmdStart), .cmdOpcode(cmdOpcode), .cmdIsGet(cmdIsGet),
        .paramValid(paramValid), .paramByte(paramByte), .cmdEnd(cmdEnd),
        .pointX(pointX), .pointY(pointY), .pointLum(pointLum),
        .sensorRgb(sensorRgb), .idealDuty(idealDuty),
        .dutyTable(dutyTable), .replyReady(replyReady),
        .replyValid(replyValid), .replyByte(replyByte),
        .replyLast(replyLast), .cmdError(cmdError), .busy(busy),
        .bypassMode(bypassMode), .appliedDuty(appliedDuty));

    wpc_host_model u_host (.clock(clock), .busy(busy),
        .replyValid(replyValid), .replyByte(replyByte),
        .replyLast(replyLast), .cmdStart(cmdStart),
        .cmdOpcode(cmdOpcode), .cmdIsGet(cmdIsGet),
        .paramValid(paramValid), .paramByte(paramByte),
        .cmdEnd(cmdEnd), .replyReady(replyReady));

    // Free-running clock, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Count refusal pulses and cut a hang short
    always @(posedge clock) begin
        if (cmdError === 1'b1) errSeen++;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reply length and each byte, low byte first
    task automatic check_reply(input logic [175:0] v, input int n);
        check(48'(u_host.rxn), 48'(n));
        for (int i = 0; i < n && i < u_host.rxn; i++)
            check({40'h0, u_host.rx[i]}, {40'h0, v[8*i+:8]});
    endtask

    // Three records stored, bad selector and short set refused
    task automatic t_cal();
        logic [71:0] rec [3];
        int e0;
        for (int c = 0; c < 3; c++) begin
            rec[c] = {32'h1000_0000 + 32'(c), 16'h2000 + 16'(c),
                      16'h3000 + 16'(c), 8'(c)};
            u_host.send(wpc_pkg::OP_CAL_DATA, 1'b0, 9, rec[c]);
        end
        e0 = errSeen;
        u_host.send(wpc_pkg::OP_CAL_DATA, 1'b0, 9, 72'h55_5555_5555_5555_5503);
        u_host.send(wpc_pkg::OP_CAL_DATA, 1'b0, 8, 72'h77_7777_7777_7777_7700);
        // Get form with a bad selector is refused as well
        u_host.send(wpc_pkg::OP_CAL_DATA, 1'b1, 1, {64'h0, 8'h05});
        repeat (3) @(negedge clock);
        check(48'(errSeen - e0), 48'd3);
        for (int c = 0; c < 3; c++) begin
            u_host.send(wpc_pkg::OP_CAL_DATA, 1'b1, 1, {64'h0, 8'(c)});
            u_host.fetch(c[0]);
            check_reply({wpc_pkg::DUTY_RESET, 16'h0, sensorRgb[47:32],
                16'h0, sensorRgb[31:16], 16'h0, sensorRgb[15:0],
                rec[c][71:8]}, 22);
        end
    endtask

    // Colour point read with stalls, sensor readings without
    task automatic t_point();
        u_host.send(wpc_pkg::OP_COLOR_POINT, 1'b1, 0, '0);
        u_host.fetch(1'b1);
        check_reply({pointLum, pointY, pointX}, 8);
        u_host.send(wpc_pkg::OP_SENSOR_OUT, 1'b1, 0, '0);
        u_host.fetch(1'b0);
        check_reply({16'h0, sensorRgb[47:32], 16'h0, sensorRgb[31:16],
                     16'h0, sensorRgb[15:0]}, 12);
        // Unknown opcode: empty reply, handler back to idle
        u_host.send(8'h00, 1'b1, 0, '0);
        u_host.fetch(1'b0);
        check(48'(u_host.rxn), 48'h0);
        check({47'h0, busy}, 48'h0);
    endtask

    // Search picks nearest table entries, then reported
    task automatic t_duty();
        logic [47:0] best;
        best = {16'h01c0, 16'h0140, 16'h0080};
        u_host.send(wpc_pkg::OP_DUTY_CYCLE, 1'b0, 0, '0);
        u_host.wait_idle();
        check(appliedDuty, best);
        u_host.send(wpc_pkg::OP_DUTY_CYCLE, 1'b1, 0, '0);
        u_host.fetch(1'b1);
        check_reply({best, idealDuty}, 12);
    endtask

    // Mode bytes 0, 2, 1, 0: only 1 enters, nothing leaves
    task automatic t_mode();
        logic [7:0] v;
        logic       exp;
        for (int i = 0; i < 4; i++) begin
            v = (i == 1) ? 8'h02 : (i == 2) ? 8'h01 : 8'h00;
            exp = (i >= 2);
            u_host.send(wpc_pkg::OP_CAL_MODE, 1'b0, 1, {64'h0, v});
            u_host.send(wpc_pkg::OP_CAL_MODE, 1'b1, 0, '0);
            u_host.fetch(1'b0);
            check_reply({175'h0, exp}, 1);
            check({47'h0, bypassMode}, {47'h0, exp});
        end
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        check({47'h0, bypassMode}, 48'h0);
        check(appliedDuty, {3{wpc_pkg::DUTY_RESET}});
    endtask

    // Main sequence; calibration loaded before colour and duty use
    initial begin
        {num_errors, check_count, errSeen, cycles} = '0;
        rst_n = 1'b0;
        pointX = 16'h5123;
        pointY = 16'h5467;
        pointLum = 32'h89ab_cdef;
        sensorRgb = {16'h0c0d, 16'h0a0b, 16'h0809};
        idealDuty = {16'h01f0, 16'h0150, 16'h0085};
        for (int i = 0; i < 8; i++) dutyTable[16*i+:16] = 16'(i * 64);
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        t_cal();
        t_point();
        t_duty();
        t_mode();
        check(48'(u_host.idleErr), 48'h0);
        close_out();
    end
endmodule
